//--- logic/sim_uart.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Internal rate is source over 16(n+1)
// - Two-bit field picks div 1/2/8/32
// - External rate is pin over 16(n+1)
// - Transmit starts when enabled and data waiting
// - Receive starts when enabled and start seen
// - Transmit interrupt when shift register done
// - Receive interrupt on buffer load
// - Overrun on unread buffer, no interrupt
// - Framing error when stop bit missing
// - Error sum follows any error flag
// - Parity error pulls transmit line low
// - Buffer read clears parity error, releases line
// - Transmit interrupt after stop bit falling edge
// - Direct format: even, LSB first, true
// - Inverse format: odd, MSB first, inverted
// - Transmit pin is open drain
module sim_uart
  import sim_uart_pkg::*;
(
  input  wire logic       ref_clk,                      // 40 MHz clock
  input  wire logic       rst_b,                        // Async reset, active low
  input  wire uart_cfg_t  cfg,                          // Mode configuration
  input  wire logic       transmit_enable_bit,          // Transmit enable
  input  wire logic       receive_enable_bit,           // Receive enable
  input  wire logic       tx_write,                     // Write strobe to transmit buffer
  input  wire logic [7:0] tx_wdata,                     // Transmit data
  input  wire logic       rx_read,                      // Read strobe of receive buffer
  output logic [7:0]      receive_buffer_reg,           // Received data
  output rx_err_t         rx_err,                       // Error flags
  output logic            transmit_buffer_empty_flag,   // Transmit buffer empty
  output logic            shift_register_empty_flag,    // Shifter idle
  output logic            receive_complete_flag,        // Receive buffer full
  output logic            tx_irq,                       // Transmit interrupt pulse
  output logic            rx_irq,                       // Receive interrupt pulse
  input  wire logic       external_bit_clock_pin,       // External clock pin
  input  wire logic       serial_receive_pin,           // Receive pin
  input  wire logic       serial_transmit_pin_in,       // Transmit pin level
  output logic            serial_transmit_pin_out,      // Transmit pin drive value
  output logic            serial_transmit_pin_oe        // High while pulling low
);

  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_DONE = 3'b100} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_BITS = 3'b010, RX_ERRSIG = 3'b100} rx_state_t;

  // Pin synchronisers
  logic [1:0] rxd_sync_r;
  logic [1:0] eck_sync_r;
  logic       eck_prev_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_sync_r <= 2'b11;
      eck_sync_r <= 2'b00;
      eck_prev_r <= 1'b0;
    end else begin
      rxd_sync_r <= {rxd_sync_r[0], serial_receive_pin};
      eck_sync_r <= {eck_sync_r[0], external_bit_clock_pin};
      eck_prev_r <= eck_sync_r[1];
    end
  end
  wire rxd = rxd_sync_r[1];
  wire eck_rise = eck_sync_r[1] & ~eck_prev_r;

  // Prescaler feeding the count source choice
  logic [4:0] pre_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) pre_r <= PRESCALE_RST;
    else        pre_r <= pre_r + 5'h01;
  end
  logic int_tick;
  always_comb begin
    case (cfg.count_source_select_field)
      SRC_DIV1:  int_tick = 1'b1;
      SRC_DIV2:  int_tick = (pre_r[0] == 1'b1);
      SRC_DIV8:  int_tick = (pre_r[2:0] == 3'h7);
      SRC_DIV32: int_tick = (pre_r == 5'h1F);
      default:   int_tick = 1'b0;
    endcase
  end
  // External edge or internal source drives the divider
  wire src_tick = cfg.clock_source_internal_external_select ? eck_rise : int_tick;

  logic ovs_tick;
  baud_gen u_baud (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .src_tick (src_tick),
    .divisor  (cfg.bit_rate_divisor_reg),
    .ovs_tick (ovs_tick)
  );

  // Format helpers: bit order and data inversion
  function automatic logic [7:0] fmt(input logic [7:0] d, input logic msb, input logic inv);
    logic [7:0] r;
    r = msb ? {<<{d}} : d;
    return inv ? ~r : r;
  endfunction
  wire even_par = cfg.parity_odd_even_select;

  // Transmit path
  tx_state_t  tx_st_r;
  logic [7:0] tx_buf_r;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_ovs_r;
  logic [3:0] tx_bit_r;
  logic       tbe_r;
  logic       txd_r;
  wire  tx_start = (tx_st_r == TX_IDLE) && transmit_enable_bit && !tbe_r && ovs_tick;
  wire  tx_bit_end = ovs_tick && (tx_ovs_r == OVS_LAST);
  wire  [7:0] tx_bits = fmt(tx_buf_r, cfg.data_order_select, cfg.data_logic_inversion_bit);
  wire  tx_par = ^tx_bits ^ ~even_par;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_r <= TX_IDLE;
      tx_buf_r <= 8'h00;
      tx_sh_r <= 10'h3FF;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tbe_r <= 1'b1;
      txd_r <= 1'b1;
    end else begin
      if (tx_write) begin
        tx_buf_r <= tx_wdata;
        tbe_r <= 1'b0;
      end
      case (tx_st_r)
        TX_IDLE: begin
          if (tx_start) begin
            tx_sh_r <= {1'b1, tx_par, tx_bits};
            tbe_r <= tx_write ? 1'b0 : 1'b1;
            txd_r <= 1'b0;
            tx_ovs_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_st_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (ovs_tick) tx_ovs_r <= tx_ovs_r + 4'h1;
          if (tx_bit_end) begin
            tx_bit_r <= tx_bit_r + 4'h1;
            txd_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            if (tx_bit_r == BIT_STOP) tx_st_r <= TX_DONE;
          end
        end
        TX_DONE: begin
          // Half a bit after the stop bit ends, the falling transfer edge
          if (ovs_tick) tx_ovs_r <= tx_ovs_r + 4'h1;
          if (ovs_tick && tx_ovs_r == OVS_MID) tx_st_r <= TX_IDLE;
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  assign transmit_buffer_empty_flag = tbe_r;
  // Shifter is empty once the stop bit has gone, even while the interrupt waits
  assign shift_register_empty_flag  = (tx_st_r != TX_SHIFT);
  // Interrupt on shifter finish (or buffer empty when cause is buffer)
  assign tx_irq = cfg.transmit_interrupt_cause_select
                ? (tx_st_r == TX_DONE && ovs_tick && tx_ovs_r == OVS_MID)
                : tx_start;

  // Receive path
  rx_state_t  rx_st_r;
  logic [3:0] rx_ovs_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic [7:0] rbuf_r;
  logic       rfull_r;
  logic       oer_r, fer_r, per_r;
  logic       ovr_pend_r;
  logic       rx_irq_r;
  wire  rx_mid = ovs_tick && (rx_ovs_r == OVS_MID);
  wire  [7:0] rx_data = fmt(rx_sh_r[7:0], cfg.data_order_select, cfg.data_logic_inversion_bit);
  wire  rx_par_bad = (^rx_sh_r[8:0]) ^ ~even_par;
  wire  clr_per = rx_read;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st_r <= RX_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rbuf_r <= 8'h00;
      rfull_r <= 1'b0;
      oer_r <= 1'b0;
      fer_r <= 1'b0;
      per_r <= 1'b0;
      ovr_pend_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end else begin
      rx_irq_r <= 1'b0;
      if (rx_read) begin
        rfull_r <= 1'b0;
        oer_r <= 1'b0;
        fer_r <= 1'b0;
      end
      if (clr_per) per_r <= 1'b0;
      if (ovs_tick && rx_st_r != RX_IDLE) rx_ovs_r <= rx_ovs_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: begin
          if (receive_enable_bit && !rxd && ovs_tick) begin
            rx_st_r <= RX_BITS;
            rx_ovs_r <= 4'h1;
            rx_bit_r <= 4'h0;
            ovr_pend_r <= 1'b0;
          end
        end
        RX_BITS: begin
          if (rx_mid) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == 4'h0 && rxd) rx_st_r <= RX_IDLE; // Glitch, not a start
            else if (rx_bit_r != 4'h0 && rx_bit_r < BIT_STOP)
              rx_sh_r <= {rxd, rx_sh_r[8:1]};
            if (rx_bit_r == BIT_OVR_CHECK && rfull_r && !rx_read)
              ovr_pend_r <= 1'b1;
            if (rx_bit_r == BIT_STOP) begin
              if (ovr_pend_r) begin
                oer_r <= 1'b1;
              end else begin
                rbuf_r <= rx_data;
                rfull_r <= 1'b1;
                rx_irq_r <= 1'b1;
                if (rx_par_bad) per_r <= 1'b1;
              end
              fer_r <= ~rxd;
              rx_st_r <= (rx_par_bad && !ovr_pend_r && cfg.error_signal_output_enable)
                       ? RX_ERRSIG : RX_IDLE;
            end
          end
        end
        RX_ERRSIG: begin
          // Hold the line low until software reads the buffer
          if (clr_per || !per_r) rx_st_r <= RX_IDLE;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  assign receive_buffer_reg    = rbuf_r;
  assign receive_complete_flag = rfull_r;
  assign rx_irq                = rx_irq_r;
  assign rx_err.overrun_error_flag = oer_r;
  assign rx_err.framing_error_flag = fer_r;
  assign rx_err.parity_error_flag  = per_r;
  assign rx_err.error_sum          = oer_r | fer_r | per_r;

  // Open-drain pin: only ever pulls low, release on buffer read
  wire err_low = (rx_st_r == RX_ERRSIG) && !clr_per;
  assign serial_transmit_pin_out = 1'b0;
  assign serial_transmit_pin_oe  = ~txd_r | err_low;

endmodule : sim_uart
`default_nettype wire

//--- logic/sim_uart_pkg.sv
package sim_uart_pkg;

  // Frame layout
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam logic [3:0]  OVS_LAST       = 4'hF;
  localparam logic [3:0]  OVS_MID        = 4'h7;
  localparam logic [3:0]  BIT_PARITY     = 4'h9;
  localparam logic [3:0]  BIT_STOP       = 4'hA;
  localparam logic [3:0]  BIT_OVR_CHECK  = 4'h9;

  // Count source selection codes
  localparam logic [1:0]  SRC_DIV1       = 2'h0;
  localparam logic [1:0]  SRC_DIV2       = 2'h1;
  localparam logic [1:0]  SRC_DIV8       = 2'h2;
  localparam logic [1:0]  SRC_DIV32      = 2'h3;
  localparam logic [4:0]  PRESCALE_RST   = 5'h00;
  localparam logic [7:0]  DIVISOR_RST    = 8'h00;
  localparam logic [2:0]  MODE_SMART     = 3'h5;

  // Configuration bits that travel together
  typedef struct packed {
    logic [2:0] serial_mode_field;
    logic       clock_source_internal_external_select;
    logic [1:0] count_source_select_field;
    logic [7:0] bit_rate_divisor_reg;
    logic       parity_odd_even_select;
    logic       data_order_select;
    logic       data_logic_inversion_bit;
    logic       error_signal_output_enable;
    logic       transmit_interrupt_cause_select;
  } uart_cfg_t;

  // Receive error flags
  typedef struct packed {
    logic overrun_error_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic error_sum;
  } rx_err_t;

endpackage : sim_uart_pkg

//--- logic/baud_gen.sv
`timescale 1ns/100ps
`default_nettype none
module baud_gen
  import sim_uart_pkg::*;
(
  input  wire logic       ref_clk,   // System clock
  input  wire logic       rst_b,     // Async reset, active low
  input  wire logic       src_tick,  // Selected count source enable
  input  wire logic [7:0] divisor,   // Divisor setting n
  output logic            ovs_tick   // Pulse at 16x bit rate
);

  logic [7:0] cnt_r;
  wire        wrap = (cnt_r == 8'h00);

  // Reload on wrap gives division by n+1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
    end else if (src_tick) begin
      cnt_r <= wrap ? divisor : cnt_r - 8'h01;
    end
  end

  assign ovs_tick = src_tick & wrap;

endmodule : baud_gen
`default_nettype wire

//--- sim/sim_uart_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sim_uart_asserts
  import sim_uart_pkg::*;
(
  input wire logic      ref_clk,                    // Clock
  input wire logic      rst_b,                      // Reset, active low
  input wire uart_cfg_t cfg,                        // Configuration
  input wire logic      transmit_enable_bit,        // Tx enable
  input wire logic      receive_enable_bit,         // Rx enable
  input wire logic      tx_write,                   // Buffer write
  input wire logic      rx_read,                    // Buffer read
  input wire rx_err_t   rx_err,                     // Error flags
  input wire logic      transmit_buffer_empty_flag, // Tx buffer empty
  input wire logic      shift_register_empty_flag,  // Shifter idle
  input wire logic      receive_complete_flag,      // Rx buffer full
  input wire logic      tx_irq,                     // Tx pulse
  input wire logic      rx_irq,                     // Rx pulse
  input wire logic      serial_transmit_pin_out,    // Drive value
  input wire logic      serial_transmit_pin_oe      // Pull-low enable
);
  logic [9:0] rx_off_r;

  // Cycles with reception off; saturates at 1023, longer than any receive frame in use
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b) rx_off_r <= 10'h000;
    else if (receive_enable_bit) rx_off_r <= 10'h000;
    else if (rx_off_r != 10'h3FF) rx_off_r <= rx_off_r + 10'h001;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Flag and pin relations
  a_err_sum: assert property (rx_err.error_sum == (rx_err.overrun_error_flag |
    rx_err.framing_error_flag | rx_err.parity_error_flag)) else $error("error sum wrong");
  a_open_drain: assert property (serial_transmit_pin_out == 1'b0)
    else $error("transmit pin drives high");
  a_read_release: assert property (rx_read && rx_err.parity_error_flag |=>
    !rx_err.parity_error_flag && !serial_transmit_pin_oe) else $error("no release on read");
  a_rx_gate: assert property (rx_off_r == 10'h3FF |-> !rx_irq)
    else $error("receive while disabled");
  a_tx_gate: assert property (!transmit_enable_bit && shift_register_empty_flag |=>
    shift_register_empty_flag) else $error("transmit while disabled");
  a_write_full: assert property (tx_write |=> !transmit_buffer_empty_flag)
    else $error("buffer empty after write");
  a_tx_done: assert property (tx_irq && cfg.transmit_interrupt_cause_select |->
    shift_register_empty_flag) else $error("tx pulse while shifting");
  a_rx_load: assert property (rx_irq |-> ##[0:1] receive_complete_flag)
    else $error("rx pulse without data");
  a_ovr_quiet: assert property ($rose(rx_err.overrun_error_flag) |->
    not (##[0:40] rx_irq)) else $error("rx pulse on overrun");

  c_tx: cover property (tx_irq && cfg.transmit_interrupt_cause_select);
  c_err: cover property (rx_err.parity_error_flag && serial_transmit_pin_oe);
  c_ovr: cover property (rx_err.overrun_error_flag);
endmodule : sim_uart_asserts
bind sim_uart sim_uart_asserts i_sim_uart_asserts (.*);
`default_nettype wire

//--- sim/smart_card_model.sv
`timescale 1ns/100ps
`default_nettype none
module smart_card_model (
  input  wire logic        ref_clk,  // Bench clock
  input  wire logic        go,       // Start one frame
  input  wire logic [10:0] bits,     // Frame, start bit first
  input  wire logic [11:0] bit_cyc,  // Clocks per bit
  output logic             card_low  // High while card pulls line low
);
  initial card_low = 1'b0;
  // Card sender; releases the pulled-up line between frames
  always @(posedge go) begin
    for (int i = 0; i < 11; i++) begin
      card_low <= ~bits[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    card_low <= 1'b0;
  end
endmodule : smart_card_model
`default_nettype wire

//--- sim/sim_uart_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sim_uart_bench import sim_uart_pkg::*;;
  logic ref_clk, rst_b, transmit_enable_bit, receive_enable_bit, tx_write, rx_read;
  logic ext_clk, go, card_low, oe, tbe, sre, rcf, tx_irq, rx_irq, pin_out;
  logic [7:0]  tx_wdata, rdata, d;
  logic [10:0] bits, f;
  logic [11:0] bit_cyc;
  logic [11:0] bc_tab [5] = '{12'h020, 12'h040, 12'h100, 12'h400, 12'h080};
  uart_cfg_t   cfg;
  rx_err_t     rx_err;
  int n_errors = 0, checked = 0, tx_cnt = 0, rx_cnt = 0, n;
  wire line = !(oe | card_low); // Pull-up: high unless pulled low

  sim_uart i_sim_uart (.ref_clk(ref_clk), .rst_b(rst_b), .cfg(cfg),
    .transmit_enable_bit(transmit_enable_bit), .receive_enable_bit(receive_enable_bit),
    .tx_write(tx_write), .tx_wdata(tx_wdata), .rx_read(rx_read),
    .receive_buffer_reg(rdata), .rx_err(rx_err), .transmit_buffer_empty_flag(tbe),
    .shift_register_empty_flag(sre), .receive_complete_flag(rcf), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .external_bit_clock_pin(ext_clk), .serial_receive_pin(line),
    .serial_transmit_pin_in(line), .serial_transmit_pin_out(pin_out),
    .serial_transmit_pin_oe(oe));
  smart_card_model i_smart_card_model (.ref_clk(ref_clk), .go(go), .bits(bits),
    .bit_cyc(bit_cyc), .card_low(card_low));

  // 40 MHz clock and an unrelated 10 MHz external bit clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    ext_clk = 1'b0;
    #7.3;
    forever #50 ext_clk = ~ext_clk;
  end
  // Interrupt pulses last one cycle, so count them here
  always @(posedge ref_clk) begin
    if (tx_irq === 1'b1) tx_cnt++;
    if (rx_irq === 1'b1) rx_cnt++;
  end

  function automatic logic [10:0] frm(input logic [7:0] v, input logic inv);
    logic [7:0] w;
    for (int i = 0; i < 8; i++) w[i] = inv ? ~v[7-i] : v[i];
    return {1'b1, ^w ^ inv, w, 1'b0};
  endfunction : frm

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic put(input logic [7:0] v);
    @(posedge ref_clk);
    tx_wdata <= v;
    tx_write <= 1'b1;
    @(posedge ref_clk);
    tx_write <= 1'b0;
  endtask : put

  // Sample the wire at bit centres, then allow for the late tx pulse
  task automatic grab(input logic [7:0] v, input logic inv);
    int k;
    int t0;
    t0 = tx_cnt;
    for (k = 0; k < 40000 && line; k++) @(negedge ref_clk);
    repeat (bit_cyc / 2) @(negedge ref_clk);
    for (k = 0; k < 11; k++) begin
      f[k] = line;
      repeat (bit_cyc) @(negedge ref_clk);
    end
    repeat (bit_cyc) @(negedge ref_clk);
    check(f, frm(v, inv));
    check(11'(tx_cnt - t0), 11'h001);
  endtask : grab

  task automatic card(input logic [10:0] b);
    @(posedge ref_clk);
    bits <= b;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (200) @(negedge ref_clk);
  endtask : card

  task automatic rd;
    @(posedge ref_clk);
    rx_read <= 1'b1;
    @(posedge ref_clk);
    rx_read <= 1'b0;
    @(negedge ref_clk);
  endtask : rd

  initial begin
    cfg = '{MODE_SMART, 1'b0, SRC_DIV1, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    {transmit_enable_bit, receive_enable_bit, tx_write, rx_read, go, rst_b} = 6'h00;
    {tx_wdata, bits, bit_cyc} = {8'h00, 11'h7FF, 12'h010};
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    put(8'hC3);
    repeat (300) @(negedge ref_clk);
    check({sre, line}, 11'h003);
    @(posedge ref_clk);
    transmit_enable_bit <= 1'b1;
    grab(8'hC3, 1'b0);
    // Each count source, then the external pin
    for (int s = 0; s < 5; s++) begin
      @(posedge ref_clk);
      cfg.clock_source_internal_external_select <= (s == 4);
      cfg.count_source_select_field <= 2'(s);
      cfg.bit_rate_divisor_reg <= 8'h01;
      bit_cyc <= bc_tab[s];
      d = 8'h5A ^ 8'(s);
      put(d);
      grab(d, 1'b0);
    end
    @(posedge ref_clk);
    cfg <= '{MODE_SMART, 1'b0, SRC_DIV1, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    bit_cyc <= 12'h010;
    put(8'h96);
    grab(8'h96, 1'b1);
    card(frm(8'h3B, 1'b1));
    check(rcf, 1'b0);
    @(posedge ref_clk);
    receive_enable_bit <= 1'b1;
    card(frm(8'h3B, 1'b1));
    check({rdata, 3'(rx_cnt)}, 11'h1D9);
    rd();
    @(posedge ref_clk);
    cfg <= '{MODE_SMART, 1'b0, SRC_DIV1, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    card(frm(8'hE7, 1'b0));
    check(11'(rdata), 11'h0E7);
    check(11'(rx_err), 11'h000);
    rd();
    card(frm(8'h18, 1'b0) ^ 11'h200);
    check({oe, rx_err}, 11'h013);
    rd();
    check({oe, rx_err.parity_error_flag}, 11'h000);
    card(frm(8'h42, 1'b0) & 11'h3FF);
    check(rx_err, 11'h005);
    rd();
    // Low stop bit reads as a fresh start; that all-ones frame fails even parity
    repeat (300) @(negedge ref_clk);
    check({oe, rx_err}, 11'h013);
    rd();
    n = rx_cnt;
    card(frm(8'h11, 1'b0));
    card(frm(8'h22, 1'b0));
    check({rx_err.overrun_error_flag, 3'(rx_cnt - n)}, 11'h009);
    close_out();
  end

  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule : sim_uart_bench
`default_nettype wire
